// File: cgl_pkg.sv
// cgl_pkg: register map, field layout, codes and reset values for the
// glue-logic block.
// assumes a 32-bit apb slave with word-aligned registers.
package cgl_pkg;
  localparam int NUM_TABLES = 4;              // lookup tables
  localparam int NUM_PAIRS  = 2;              // sequential pairs
  localparam int ADDR_W     = 8;              // apb address width
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00; // global enable
  localparam logic [7:0] OFF_SEQCTRL = 8'h04; // sequential modes
  localparam logic [7:0] OFF_TC0     = 8'h08; // table_control 0..3
  localparam logic [7:0] OFF_STATUS  = 8'h18; // live outputs
  // global control fields
  localparam int CTRL_ENABLE = 1;             // block enable bit
  localparam int SEQ_W       = 4;             // bits per pair field
  // table_control fields
  localparam int TC_ENABLE   = 1;             // table enable
  localparam int TC_FILT_LO  = 4;             // filter select, 2 bits
  localparam int TC_EDGE     = 7;             // edge detector enable
  localparam int TC_INSEL_LO = 8;             // 3 x 4-bit selects
  localparam int INSEL_W     = 4;             // width of one select
  localparam int TC_EVI      = 21;            // event_input_enable
  localparam int TC_EVO      = 22;            // event_output_enable
  localparam int TC_PINOE    = 23;            // pin output enable
  localparam int TC_TRUTH_LO = 24;            // 8-bit truth table
  localparam logic [31:0] TC_WMASK   = 32'hFFEF_FFB2; // writable bits
  localparam logic [31:0] SEQ_WMASK  = 32'h0000_0077; // writable bits
  localparam logic [31:0] RESET_WORD = 32'h0000_0000; // reset value
  // input select codes
  localparam logic [3:0] IN_MASK   = 4'h0;    // input masked, reads 0
  localparam logic [3:0] IN_NEXT   = 4'h1;    // next table output
  localparam logic [3:0] IN_EVENT  = 4'h2;    // event input
  localparam logic [3:0] IN_IO     = 4'h3;    // i/o pin
  localparam logic [3:0] IN_PERIPH = 4'h4;    // internal peripheral
  // output stage select
  localparam logic [1:0] FILT_NONE = 2'h0;    // combinatorial
  localparam logic [1:0] FILT_SYNC = 2'h1;    // synchronizer
  localparam logic [1:0] FILT_SPK  = 2'h2;    // spike filter
  // sequential modes
  localparam logic [2:0] SEQ_OFF = 3'h0;      // no sequential element
  localparam logic [2:0] SEQ_DFF = 3'h1;      // gated d flip-flop
  localparam logic [2:0] SEQ_JK  = 3'h2;      // jk flip-flop
  localparam logic [2:0] SEQ_DL  = 3'h3;      // gated d latch
  localparam logic [2:0] SEQ_RS  = 3'h4;      // rs latch
endpackage : cgl_pkg

// File: cgl_lut.sv
// cgl_lut: one lookup table with its output stages.
// assumes inputs already selected and masked by the parent.
`timescale 1ns/1ns
`default_nettype none
module cgl_lut (
  input  wire logic       pclk,     // bus clock
  input  wire logic       presetn,  // async reset, low
  input  wire logic       ce,       // clock enable
  input  wire logic       enable,   // table enabled
  input  wire logic [1:0] filt_sel, // output stage select
  input  wire logic       edge_en,  // edge detector on
  input  wire logic [7:0] truth,    // truth table
  input  wire logic [2:0] lut_in,   // input 2 is msb
  output logic            lut_out   // registered result
);
  logic raw;      // truth table result
  logic s1_reg;   // synchronizer first stage
  logic s2_reg;   // synchronizer second stage
  logic s3_reg;   // delayed copy for filter
  logic filt_reg; // filtered value
  logic prev_reg; // last stage value for edges
  logic stage;    // selected stage value
  logic out_next; // next output

  // truth table lookup by input index
  assign raw = truth[lut_in];

  // synchronizer chain and filter sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // filter passes a value only once two samples agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) filt_reg <= 1'b0;
    else if (ce && (s2_reg == s3_reg)) filt_reg <= s3_reg;
  end

  // stage select
  always_comb begin
    case (filt_sel)
      cgl_pkg::FILT_SYNC: stage = s2_reg;
      cgl_pkg::FILT_SPK:  stage = filt_reg;
      default:            stage = raw;
    endcase
    out_next = edge_en ? (stage & ~prev_reg) : stage;
  end

  // edge memory and output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      lut_out  <= 1'b0;
    end else if (ce) begin
      prev_reg <= enable & stage;
      lut_out  <= enable & out_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_truth_out: assert property (
    (ce && enable && !edge_en && filt_sel == cgl_pkg::FILT_NONE)
      |=> lut_out == $past(truth[lut_in]))
    else $error("table output does not match truth bit");
  chk_edge_pulse: assert property (
    (ce && edge_en && lut_out) |=> !lut_out)
    else $error("edge detector pulse longer than one cycle");
endmodule : cgl_lut
`default_nettype wire

// File: cgl_seq.sv
// cgl_seq: sequential element for one table pair.
// assumes even and odd inputs come from registered table outputs.
`timescale 1ns/1ns
`default_nettype none
module cgl_seq (
  input  wire logic       pclk,    // bus clock
  input  wire logic       presetn, // async reset, low
  input  wire logic       ce,      // clock enable
  input  wire logic [2:0] mode,    // sequential mode
  input  wire logic       even_en, // even table enabled
  input  wire logic       in_even, // d, j or s
  input  wire logic       in_odd,  // gate, k or r
  output logic            seq_out  // element output
);
  logic r_hold_reg; // r forced for one more cycle
  logic g_prev_reg; // gate history for flip-flop
  logic s_in;       // effective set
  logic r_in;       // effective reset
  logic is_rs;      // rs mode

  assign is_rs = (mode == cgl_pkg::SEQ_RS);
  // forced inputs while even table is off or just turned back on
  assign s_in = even_en & ~r_hold_reg & in_even;
  assign r_in = in_odd | ~even_en | r_hold_reg;

  // r hold runs while the even table is off and one cycle after it is re-enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r_hold_reg <= 1'b0;
    else if (ce) r_hold_reg <= is_rs & ~even_en;
  end

  // gate history for the edge-triggered flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) g_prev_reg <= 1'b0;
    else if (ce) g_prev_reg <= in_odd;
  end

  // element update per mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seq_out <= 1'b0;
    else if (ce) begin
      case (mode)
        cgl_pkg::SEQ_DFF: begin
          if (in_odd && !g_prev_reg) seq_out <= in_even;
        end
        cgl_pkg::SEQ_JK: begin
          case ({in_even, in_odd})
            2'b01:   seq_out <= 1'b0;
            2'b10:   seq_out <= 1'b1;
            2'b11:   seq_out <= ~seq_out;
            default: seq_out <= seq_out;
          endcase
        end
        cgl_pkg::SEQ_DL: begin
          if (in_odd) seq_out <= in_even;
        end
        cgl_pkg::SEQ_RS: begin
          if (!even_en) seq_out <= 1'b0;
          else if (s_in && !r_in) seq_out <= 1'b1;
          else if (!s_in && r_in) seq_out <= 1'b0;
        end
        default: seq_out <= 1'b0;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rs_off_then_on;
    (ce && is_rs && !even_en) ##1 (ce && is_rs && even_en);
  endsequence
  chk_rs_clear: assert property (
    (ce && is_rs && !even_en) |=> !seq_out)
    else $error("rs latch not cleared with even table off");
  chk_rs_rhold: assert property (
    rs_off_then_on |=> !seq_out)
    else $error("rs latch set during forced reset cycle");
  chk_rs_set: assert property (
    (ce && is_rs && s_in && !r_in) |=> seq_out)
    else $error("rs latch did not set");
  chk_latch_hold: assert property (
    (ce && mode == cgl_pkg::SEQ_DL && !in_odd) |=> $stable(seq_out))
    else $error("d latch changed with gate low");
  chk_latch_follow: assert property (
    (ce && mode == cgl_pkg::SEQ_DL && in_odd) |=> seq_out == $past(in_even))
    else $error("d latch did not follow d");
endmodule : cgl_seq
`default_nettype wire

// File: cgl_top.sv
// cgl_top: configurable glue logic with four lookup tables,
// two sequential pairs and an apb register slave.
// assumes apb master and all pin, event and peripheral inputs are
// synchronous to pclk.
//
// What this block does
// - each table: inputs, truth, filter, edge stages
// - each table input individually maskable
// - four independently programmable lookup tables
// - truth table realises any gate function
// - inputs from pins, events, peripherals, next table
// - optional synchronizer, spike filter, edge detector
// - table output drives pins and events
// - pairs 0/1 and 2/3 feed sequential element
// - modes: d flip-flop, jk, d latch, rs
// - d latch holds gate low, follows gate high
// - rs set from even, reset from odd
// - even table off clears latch, forces reset; rs mode only here, other modes just get a 0 even input
// - rs hold, clear, set; both high forbidden
// - event_output_enable gates output event
// - event_input_enable lets events feed tables
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cgl_top #(
  parameter int NT = cgl_pkg::NUM_TABLES // table count, even
) (
  input  wire logic          pclk,      // bus clock
  input  wire logic          presetn,   // async reset, low
  input  wire logic          ce,        // clock enable
  input  wire logic          psel,      // apb select
  input  wire logic          penable,   // apb enable
  input  wire logic          pwrite,    // apb direction
  input  wire logic [7:0]    paddr,     // apb byte address
  input  wire logic [31:0]   pwdata,    // apb write data
  output logic      [31:0]   prdata,    // apb read data
  output logic               pready,    // apb ready
  output logic               pslverr,   // apb error
  input  wire logic [3*NT-1:0] io_in,   // pin inputs
  input  wire logic [NT-1:0] event_in,  // event inputs
  input  wire logic [3*NT-1:0] periph_in, // peripheral inputs
  output logic      [NT-1:0] pin_out,   // pin output values
  output logic      [NT-1:0] pin_oe,    // pin output enables
  output logic      [NT-1:0] table_output_event // event outputs
);
  localparam int NP = NT / 2; // pairs

  logic             glue_en_reg;             // global enable
  logic [2:0]       seq_mode_reg [NP];       // pair modes
  logic [31:0]      table_control_reg [NT];  // per-table control
  logic             rd_ready_reg;            // answer pending
  logic [NT-1:0]    lut_q;                   // table results
  logic [NT-1:0]    final_q;                 // after sequential
  logic [NP-1:0]    seq_q;                   // pair outputs
  logic [2:0]       lut_in [NT];             // selected inputs
  logic             access;                  // apb access phase
  logic             wr_take;                 // write completes
  logic [31:0]      rd_word;                 // read mux

  // one input bit from its select code
  function automatic logic pick_input(
    input logic [3:0] code,
    input logic       io_bit,
    input logic       ev_bit,
    input logic       pe_bit,
    input logic       nx_bit
  );
    logic v;
    v = 1'b0;
    case (code)
      cgl_pkg::IN_NEXT:   v = nx_bit;
      cgl_pkg::IN_EVENT:  v = ev_bit;
      cgl_pkg::IN_IO:     v = io_bit;
      cgl_pkg::IN_PERIPH: v = pe_bit;
      default:            v = 1'b0; // masked
    endcase
    return v;
  endfunction : pick_input

  // true when the address names a register
  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = (a == cgl_pkg::OFF_CTRL) || (a == cgl_pkg::OFF_SEQCTRL) ||
        (a == cgl_pkg::OFF_STATUS) ||
        ((a >= cgl_pkg::OFF_TC0) &&
         (a < cgl_pkg::OFF_TC0 + 8'(4 * NT)) && (a[1:0] == 2'b00));
    return m;
  endfunction : mapped

  // table index of a table_control address
  function automatic int tc_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - cgl_pkg::OFF_TC0;
    return int'(d[7:2]);
  endfunction : tc_index

  assign access  = psel & penable;
  assign wr_take = access & rd_ready_reg & pwrite & mapped(paddr);

  // read mux
  always_comb begin
    rd_word = cgl_pkg::RESET_WORD;
    if (paddr == cgl_pkg::OFF_CTRL)
      rd_word[cgl_pkg::CTRL_ENABLE] = glue_en_reg;
    else if (paddr == cgl_pkg::OFF_SEQCTRL) begin
      for (int p = 0; p < NP; p++)
        rd_word[p*cgl_pkg::SEQ_W +: 3] = seq_mode_reg[p];
    end else if (paddr == cgl_pkg::OFF_STATUS)
      rd_word[NT-1:0] = final_q;
    else if (mapped(paddr))
      rd_word = table_control_reg[tc_index(paddr)];
  end

  // apb answer: one wait state, then ready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ready_reg <= 1'b0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= cgl_pkg::RESET_WORD;
    end else if (ce) begin
      rd_ready_reg <= access & ~rd_ready_reg;
      pready       <= access & ~rd_ready_reg;
      pslverr      <= access & ~rd_ready_reg & ~mapped(paddr);
      if (access && !rd_ready_reg && !pwrite)
        prdata <= rd_word; // read data held until next read
    end
  end

  // global enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) glue_en_reg <= 1'b0;
    else if (ce && wr_take && paddr == cgl_pkg::OFF_CTRL)
      glue_en_reg <= pwdata[cgl_pkg::CTRL_ENABLE];
  end

  // sequential mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) seq_mode_reg[p] <= 3'h0;
    end else if (ce && wr_take && paddr == cgl_pkg::OFF_SEQCTRL) begin
      for (int p = 0; p < NP; p++)
        seq_mode_reg[p] <= pwdata[p*cgl_pkg::SEQ_W +: 3];
    end
  end

  // table_control registers, writable bits only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < NT; t++)
        table_control_reg[t] <= cgl_pkg::RESET_WORD;
    end else if (ce && wr_take && paddr >= cgl_pkg::OFF_TC0 &&
                 paddr != cgl_pkg::OFF_STATUS &&
                 paddr != cgl_pkg::OFF_SEQCTRL) begin
      table_control_reg[tc_index(paddr)] <=
        pwdata & cgl_pkg::TC_WMASK;
    end
  end

  // per-table input selection and lookup table
  for (genvar t = 0; t < NT; t++) begin : g_tab
    logic [31:0] tc;  // this table's control
    logic        en;  // effective enable
    logic        ev;  // event input after enable
    assign tc = table_control_reg[t];
    assign en = glue_en_reg & tc[cgl_pkg::TC_ENABLE];
    assign ev = event_in[t] & tc[cgl_pkg::TC_EVI];

    // three inputs, each with its own select and mask
    for (genvar k = 0; k < 3; k++) begin : g_in
      localparam int LO = cgl_pkg::TC_INSEL_LO + k*cgl_pkg::INSEL_W;
      assign lut_in[t][k] = pick_input(
        tc[LO +: cgl_pkg::INSEL_W], io_in[3*t+k], ev,
        periph_in[3*t+k], final_q[(t+1) % NT]);
    end

    cgl_lut u_lut (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .enable   (en),
      .filt_sel (tc[cgl_pkg::TC_FILT_LO +: 2]),
      .edge_en  (tc[cgl_pkg::TC_EDGE]),
      .truth    (tc[cgl_pkg::TC_TRUTH_LO +: 8]),
      .lut_in   (lut_in[t]),
      .lut_out  (lut_q[t])
    );

    chk_mask_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tc[cgl_pkg::TC_INSEL_LO +: cgl_pkg::INSEL_W] == cgl_pkg::IN_MASK)
        |-> !lut_in[t][0])
      else $error("masked input not zero");
    chk_evt_in_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!tc[cgl_pkg::TC_EVI] && tc[cgl_pkg::TC_INSEL_LO +: 4] ==
        cgl_pkg::IN_EVENT) |-> !lut_in[t][0])
      else $error("event reached table with input disabled");
  end

  // sequential element per adjacent pair
  for (genvar p = 0; p < NP; p++) begin : g_pair
    logic even_en; // even table effective enable
    assign even_en = glue_en_reg &
                     table_control_reg[2*p][cgl_pkg::TC_ENABLE];
    cgl_seq u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .mode    (seq_mode_reg[p]),
      .even_en (even_en),
      .in_even (lut_q[2*p]),
      .in_odd  (lut_q[2*p+1]),
      .seq_out (seq_q[p])
    );
    // sequential output replaces the even table output
    assign final_q[2*p] = (seq_mode_reg[p] == cgl_pkg::SEQ_OFF) ?
                          lut_q[2*p] : seq_q[p];
    assign final_q[2*p+1] = lut_q[2*p+1];
  end

  // pin and event output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out            <= '0;
      pin_oe             <= '0;
      table_output_event <= '0;
    end else if (ce) begin
      for (int t = 0; t < NT; t++) begin
        pin_out[t] <= final_q[t];
        pin_oe[t]  <= glue_en_reg & table_control_reg[t][cgl_pkg::TC_PINOE];
        table_output_event[t] <= final_q[t] &
          table_control_reg[t][cgl_pkg::TC_EVO];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_first_access;
    ce && access && !rd_ready_reg;
  endsequence
  chk_apb_wait: assert property (
    apb_first_access |=> pready ##1 !pready || !ce)
    else $error("apb answer not after one wait state");
  chk_apb_unmapped: assert property (
    (apb_first_access and !mapped(paddr)) |=> pslverr && pready)
    else $error("unmapped address gave no error");
  chk_evt_out_gate: assert property (
    (ce && !table_control_reg[0][cgl_pkg::TC_EVO]) |=>
      !table_output_event[0])
    else $error("event output while disabled");
  chk_pin_route: assert property (
    ce |=> pin_out == $past(final_q))
    else $error("pin output does not follow table output");
endmodule : cgl_top
`default_nettype wire

// File: cgl_far_model.sv
// cgl_far_model: pins, events and peripherals beside the glue logic.
// assumes the bench picks the levels; they launch on the next edge.
`timescale 1ns/1ns
`default_nettype none
module cgl_far_model (
  input  wire logic        pclk,     // bus clock
  input  wire logic        presetn,  // async reset, low
  input  wire logic [27:0] want,     // io, event, periph levels
  output logic      [11:0] io_in,    // pin levels
  output logic      [3:0]  event_in, // event levels
  output logic      [11:0] periph_in // peripheral levels
);
  // sources are synchronous to pclk, so they change just after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {io_in, event_in, periph_in} <= '0; // quiet while in reset
    end else begin
      {io_in, event_in, periph_in} <= want;
    end
  end
endmodule : cgl_far_model
`default_nettype wire

// File: tb_cgl_top.sv
// tb_cgl_top: random and directed checks of the glue-logic block.
// assumes cgl_pkg, cgl_top and cgl_far_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_cgl_top;
  logic        pclk, presetn, ce, psel, penable, pwrite; // bus, enable
  logic [7:0]  paddr;                   // byte address
  logic [31:0] pwdata, prdata, rd;      // data and last read
  logic        pready, pslverr, err;    // answer and last error
  logic [11:0] io_in, periph_in;        // far-side levels
  logic [3:0]  event_in, pin_out, pin_oe, tev, expo; // table outputs
  logic [27:0] want;                    // levels asked of far side
  logic [31:0] tc [4];                  // model of table_control
  logic        e, o, q, g0;             // pair model state
  int          miscompares, num_checks; // counters
  cgl_top #(.NT(4)) u_cgl_top (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_in(io_in), .event_in(event_in),
    .periph_in(periph_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .table_output_event(tev));
  cgl_far_model u_cgl_far_model (.pclk(pclk), .presetn(presetn),
    .want(want), .io_in(io_in), .event_in(event_in),
    .periph_in(periph_in));
  // 25 MHz bus clock
  always #20 pclk = ~pclk;
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // print counts and verdict, then end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle edge so a next call never re-drives psel
  endtask : apb
  // random input select among masked, event, pin and peripheral
  function automatic logic [3:0] cd();
    logic [3:0] c;
    c = 4'($urandom_range(4));
    return (c == 4'h1) ? 4'h0 : c;
  endfunction : cd
  // expected steady table output from the model registers
  function automatic logic lut(input int t);
    logic [2:0] ix;
    for (int k = 0; k < 3; k++) begin
      case (tc[t][8+4*k +: 4])
        4'h2:    ix[k] = tc[t][21] & want[12+t];
        4'h3:    ix[k] = want[16+3*t+k];
        4'h4:    ix[k] = want[3*t+k];
        default: ix[k] = 1'b0;
      endcase
    end
    return tc[t][24+ix];
  endfunction : lut
  // watchdog cuts a hang short
  initial begin
    #(40*20000);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata, want} = '0;
    ce = 1'b1;
    void'($urandom(95));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 24; a += 4) begin
      apb(0, 8'(a), 0);
      chk(rd, cgl_pkg::RESET_WORD);
    end
    apb(0, 8'h1C, 0);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1, cgl_pkg::OFF_SEQCTRL, 32'hFFFF_FFFF);
    apb(0, cgl_pkg::OFF_SEQCTRL, 0);
    chk(rd, cgl_pkg::SEQ_WMASK);
    apb(1, cgl_pkg::OFF_SEQCTRL, 0);
    apb(1, cgl_pkg::OFF_CTRL, 32'h0000_0002);
    // random tables, selects, stages and levels
    for (int it = 0; it < 40; it++) begin
      for (int t = 0; t < 4; t++) begin
        tc[t] = {8'($urandom), 3'($urandom), 1'b0, cd(), cd(), cd(),
                 2'b00, 2'($urandom_range(2)), 4'h2};
        apb(1, cgl_pkg::OFF_TC0 + 8'(4*t), tc[t]);
        apb(0, cgl_pkg::OFF_TC0 + 8'(4*t), 0);
        chk(rd, tc[t]);
      end
      want <= 28'($urandom);
      repeat (12) @(posedge pclk);
      for (int t = 0; t < 4; t++) begin
        expo[t] = lut(t);
      end
      chk(pin_out, expo);
      chk(tev, expo & {tc[3][22], tc[2][22], tc[1][22], tc[0][22]});
      chk(pin_oe, {tc[3][23], tc[2][23], tc[1][23], tc[0][23]});
      apb(0, cgl_pkg::OFF_STATUS, 0);
      chk(rd, 32'(expo));
    end
    // pair 0: each table copies its pin input 0
    tc[0] = 32'hAA00_0302;
    apb(1, cgl_pkg::OFF_TC0, tc[0]);
    apb(1, cgl_pkg::OFF_TC0 + 8'h04, tc[0]);
    for (int m = 1; m < 5; m++) begin
      apb(1, cgl_pkg::OFF_SEQCTRL, 32'(m));
      {e, o, g0} = 3'b000;
      for (int s = 0; s < 16; s++) begin
        if (s == 1) begin
          o = 1'b1;
        end else if (s > 1) begin
          if ($urandom_range(1)) o = !o;
          else e = !e;
          if (e && o) {e, o} = 2'b00;
        end
        case (m)
          1: if (o && !g0) q = e;
          2, 4: if (e != o) q = e;
          default: if (o) q = e;
        endcase
        g0 = o;
        want <= (28'(e) << 16) | (28'(o) << 19);
        repeat (10) @(posedge pclk);
        if (s > 0) chk(pin_out[1:0], {o, q});
      end
    end
    want <= 28'h001_0000;
    repeat (10) @(posedge pclk);
    chk(pin_out[0], 1'b1);
    apb(1, cgl_pkg::OFF_TC0, 32'hAA00_0300);
    want <= 28'h0;
    repeat (10) @(posedge pclk);
    chk(pin_out[0], 1'b0);
    apb(1, cgl_pkg::OFF_TC0, tc[0]);
    repeat (10) @(posedge pclk);
    chk(pin_out[0], 1'b0);
    // clock enable low freezes every output
    for (int t = 0; t < 4; t++) begin
      expo[t] = (t > 1) ? lut(t) : 1'b0;
    end
    ce <= 1'b0;
    want <= 28'hFFF_FFFF;
    repeat (10) @(posedge pclk);
    chk(pin_out, expo);
    ce <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(pin_out[3:2], {lut(3), lut(2)});
    // table 1 reads the final output of table 2
    apb(1, cgl_pkg::OFF_TC0 + 8'h04, 32'hAA00_0102);
    repeat (10) @(posedge pclk);
    chk(pin_out[1], lut(2));
    // rising edge on table 3 input gives a one-cycle pulse
    apb(1, cgl_pkg::OFF_TC0 + 8'h0C, 32'hAA00_0382);
    want <= 28'h000_0000;
    repeat (10) @(posedge pclk);
    want <= 28'h200_0000;
    repeat (4) @(posedge pclk);
    chk(pin_out[3], 1'b1);
    @(posedge pclk);
    chk(pin_out[3], 1'b0);
    apb(1, cgl_pkg::OFF_CTRL, 0);
    repeat (10) @(posedge pclk);
    chk({pin_out, pin_oe}, 8'h00);
    stop_test();
  end
endmodule : tb_cgl_top
`default_nettype wire
